//--- verilog/prog_writer_map.vh
`ifndef PROG_WRITER_MAP_VH
`define PROG_WRITER_MAP_VH
// byte offsets on the register bus
`define OFS_CONTROL 8'h00
`define OFS_ADDR_LO 8'h04
`define OFS_ADDR_HI 8'h08
`define OFS_KEY 8'h0c
`define OFS_SRC 8'h10
`define OFS_LATCH0 8'h14
`define OFS_LATCH1 8'h18
`define OFS_STATUS 8'h1c
`define OFS_MASK 8'h20
// control fields
`define CTL_START 15
`define CTL_WREN 14
`define CTL_ERR 13
`define OP_DOUBLE 4'h1
`define OP_ROW 4'h2
`define CONTROL_RESET 16'h0000
// unlock key pair
`define KEY_FIRST 8'h55
`define KEY_SECOND 8'haa
// row of 64 double words is 128 instruction words
`define ROW_WORDS 8'h80
`define ROW_MASK 24'h00007f
`define DBL_MASK 24'h000001
`endif

//--- verilog/word_latch.v
// two-entry instruction write latch, registered read
module word_latch (
  input wire clock_i, // core clock
  input wire reset_n_i, // sync reset, active low
  input wire wr_i, // write strobe
  input wire wsel_i, // write entry
  input wire [23:0] wdata_i, // write data
  input wire rsel_i, // read entry
  output reg [23:0] rdata_o // registered read data
);
  reg [23:0] mem0;
  reg [23:0] mem1;

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      mem0 <= 24'h000000;
      mem1 <= 24'h000000;
      rdata_o <= 24'h000000;
    end
    else
    begin
      if (wr_i && !wsel_i)
        mem0 <= wdata_i;
      if (wr_i && wsel_i)
        mem1 <= wdata_i;
      rdata_o <= rsel_i ? mem1 : mem0;
    end
  end
endmodule

//--- verilog/runtime_program_memory_writer.v
// The address map and register access over AHB-Lite were chosen for this implementation.
`include "prog_writer_map.vh"
module runtime_program_memory_writer (
  input wire clock_i, // core clock 100 MHz
  input wire reset_n_i, // sync reset, active low
  input wire hsel_i, // ahb slave select
  input wire [31:0] haddr_i, // ahb address
  input wire [1:0] htrans_i, // ahb transfer type
  input wire hwrite_i, // ahb write
  input wire [2:0] hsize_i, // ahb size
  input wire [31:0] hwdata_i, // ahb write data
  input wire hready_i, // ahb bus ready
  output reg [31:0] hrdata_o, // ahb read data
  output reg hreadyout_o, // ahb slave ready
  output reg hresp_o, // ahb response, always okay
  output reg cpu_stall_o, // processor stall, high while busy
  output reg irq_o, // completion or refusal interrupt level
  output reg slave_code_ram_we_o, // code ram write strobe
  output reg [23:0] slave_code_ram_addr_o, // code ram word address
  output reg [23:0] slave_code_ram_wdata_o, // code ram write data
  output reg dram_re_o, // data ram read strobe
  output reg [15:0] dram_addr_o, // data ram word address
  input wire [23:0] dram_rdata_i // data ram data, next cycle
);
  // ==========================================================
  // state
  localparam ST_IDLE = 3'd0;
  localparam ST_DBL0 = 3'd1;
  localparam ST_DBL1 = 3'd2;
  localparam ST_ROWRD = 3'd3;
  localparam ST_ROWWR = 3'd4;
  localparam ST_DONE = 3'd5;

  // unlock progress: nothing, first key seen, both keys seen
  localparam KEY_NONE = 2'd0;
  localparam KEY_HALF = 2'd1;
  localparam KEY_OPEN = 2'd2;

  reg [2:0] state;
  reg [15:0] control;
  reg [15:0] addr_lo;
  reg [7:0] addr_hi;
  reg [15:0] src_addr;
  reg [1:0] key_stage;
  reg [1:0] status;
  reg [1:0] mask;
  reg [7:0] count;
  reg [23:0] base;
  reg ph_valid;
  reg ph_write;
  reg [7:0] ph_addr;
  reg read_clear;
  reg [31:0] next_rdata;
  reg [1:0] next_status;

  // ==========================================================
  // helpers
  function aligned;
    input [23:0] a;
    input [23:0] m;
    begin
      aligned = ((a & m) == 24'h000000);
    end
  endfunction

  function at_reg;
    input [7:0] a;
    input [7:0] ofs;
    begin
      at_reg = (a == ofs);
    end
  endfunction

  function is_double;
    input [3:0] op;
    begin
      is_double = (op == `OP_DOUBLE);
    end
  endfunction

  function is_row;
    input [3:0] op;
    begin
      is_row = (op == `OP_ROW);
    end
  endfunction

  // code ram word address of the n-th word of the unit
  function [23:0] word_addr;
    input [23:0] b;
    input [7:0] n;
    begin
      word_addr = b + {16'h0000, n};
    end
  endfunction

  function [7:0] bump;
    input [7:0] n;
    begin
      bump = n + 8'h01;
    end
  endfunction

  // ==========================================================
  // decode
  wire [23:0] target = {addr_hi, addr_lo};
  wire [3:0] opcode = control[3:0];
  wire take = hsel_i && hready_i && htrans_i[1];
  wire wr_now = ph_valid && ph_write;
  wire latch_sel = at_reg(ph_addr, `OFS_LATCH1);
  wire latch_wr = wr_now && (at_reg(ph_addr, `OFS_LATCH0) || latch_sel);
  wire [23:0] latch_q;
  // entry 0 is read while count is even, so it lands with word 0
  wire latch_rsel = count[0];

  // ==========================================================
  // write latches
  word_latch u_latch (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .wr_i(latch_wr),
    .wsel_i(latch_sel),
    .wdata_i(hwdata_i[23:0]),
    .rsel_i(latch_rsel),
    .rdata_o(latch_q)
  );

  // ==========================================================
  // bus slave, zero wait states
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      ph_valid <= take;
      if (take)
      begin
        ph_write <= hwrite_i;
        ph_addr <= haddr_i[7:0];
      end
    end
  end

  // read data chosen in the address phase, registered
  always @*
  begin
    next_rdata = 32'h00000000;
    read_clear = 1'b0;
    case (haddr_i[7:0])
      `OFS_CONTROL: next_rdata = {16'h0000, control};
      `OFS_ADDR_LO: next_rdata = {16'h0000, addr_lo};
      `OFS_ADDR_HI: next_rdata = {24'h000000, addr_hi};
      `OFS_KEY: next_rdata = 32'h00000000;
      `OFS_SRC: next_rdata = {16'h0000, src_addr};
      `OFS_STATUS:
      begin
        next_rdata = {30'h00000000, status};
        read_clear = take && !hwrite_i;
      end
      `OFS_MASK: next_rdata = {30'h00000000, mask};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
      hrdata_o <= 32'h00000000;
    else if (take && !hwrite_i)
      hrdata_o <= next_rdata;
  end

  // ==========================================================
  // registers and unlock
  wire key_wr = wr_now && at_reg(ph_addr, `OFS_KEY);
  wire ctl_wr = wr_now && at_reg(ph_addr, `OFS_CONTROL);
  wire start_req = ctl_wr && hwdata_i[`CTL_START] && state == ST_IDLE;
  wire unlocked = key_stage == KEY_OPEN && control[`CTL_WREN];
  wire op_ok = (is_double(opcode) && aligned(target, `DBL_MASK)) ||
               (is_row(opcode) && aligned(target, `ROW_MASK));
  wire launch = start_req && unlocked && op_ok;
  // a start that is refused leaves the flag low and flags an error
  wire refused = start_req && !launch;
  wire finish = state == ST_DONE;

  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      control <= `CONTROL_RESET;
      addr_lo <= 16'h0000;
      addr_hi <= 8'h00;
      src_addr <= 16'h0000;
      key_stage <= KEY_NONE;
      mask <= 2'b00;
    end
    else
    begin
      // key pair must be the two writes right before the start
      if (key_wr && hwdata_i[7:0] == `KEY_FIRST)
        key_stage <= KEY_HALF;
      else if (key_wr && key_stage == KEY_HALF &&
               hwdata_i[7:0] == `KEY_SECOND)
        key_stage <= KEY_OPEN;
      else if (wr_now)
        key_stage <= KEY_NONE;
      if (ctl_wr && state == ST_IDLE)
      begin
        control[`CTL_WREN] <= hwdata_i[`CTL_WREN];
        control[3:0] <= hwdata_i[3:0];
        control[`CTL_START] <= launch;
        control[`CTL_ERR] <= refused;
      end
      else if (finish)
        control[`CTL_START] <= 1'b0;
      if (state == ST_IDLE && wr_now)
      begin
        if (ph_addr == `OFS_ADDR_LO)
          addr_lo <= hwdata_i[15:0];
        if (ph_addr == `OFS_ADDR_HI)
          addr_hi <= hwdata_i[7:0];
        if (ph_addr == `OFS_SRC)
          src_addr <= hwdata_i[15:0];
      end
      if (wr_now && ph_addr == `OFS_MASK)
        mask <= hwdata_i[1:0];
    end
  end

  // ==========================================================
  // sequencer: one unit per launch
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      state <= ST_IDLE;
      count <= 8'h00;
      base <= 24'h000000;
      cpu_stall_o <= 1'b0;
      slave_code_ram_we_o <= 1'b0;
      slave_code_ram_addr_o <= 24'h000000;
      slave_code_ram_wdata_o <= 24'h000000;
      dram_re_o <= 1'b0;
      dram_addr_o <= 16'h0000;
    end
    else
    begin
      slave_code_ram_we_o <= 1'b0;
      dram_re_o <= 1'b0;
      case (state)
        ST_IDLE:
          if (launch)
          begin
            base <= target;
            count <= 8'h00;
            cpu_stall_o <= 1'b1;
            state <= is_double(opcode) ? ST_DBL0 : ST_ROWRD;
          end
        ST_DBL0:
          state <= ST_DBL1;
        ST_DBL1:
        begin
          // latch read is registered; entries come out in order
          slave_code_ram_we_o <= 1'b1;
          slave_code_ram_addr_o <= word_addr(base, count);
          slave_code_ram_wdata_o <= latch_q;
          count <= bump(count);
          state <= (count == 8'h01) ? ST_DONE : ST_DBL0;
        end
        ST_ROWRD:
        begin
          dram_re_o <= 1'b1;
          dram_addr_o <= src_addr + {8'h00, count};
          state <= ST_ROWWR;
        end
        ST_ROWWR:
          if (!dram_re_o)
          begin
            slave_code_ram_we_o <= 1'b1;
            slave_code_ram_addr_o <= word_addr(base, count);
            slave_code_ram_wdata_o <= dram_rdata_i;
            count <= bump(count);
            state <= (count == `ROW_WORDS - 8'h01) ? ST_DONE : ST_ROWRD;
          end
        ST_DONE:
        begin
          cpu_stall_o <= 1'b0;
          state <= ST_IDLE;
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // interrupt: bit0 done, bit1 refused; set beats read clear
  always @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      status <= 2'b00;
      irq_o <= 1'b0;
    end
    else
    begin
      status <= next_status;
      irq_o <= |(status & mask);
    end
  end

  // a read clears, but an event in the same cycle still sets
  always @*
  begin
    next_status = status;
    if (read_clear)
      next_status = 2'b00;
    if (finish)
      next_status[0] = 1'b1;
    if (refused)
      next_status[1] = 1'b1;
  end
  // code ram is plain volatile storage outside
endmodule

//--- tb/data_ram_partner.sv
// ======
// data ram answering the row fetch one cycle after the read pulse
module data_ram_partner (
  input wire logic clock_i, // core clock
  input wire logic re_i, // read pulse
  input wire logic [15:0] addr_i, // word address
  output logic [23:0] rdata_o // read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rdata_o = 24'h000000;
  // unread cycles show the inverse so stale data never passes
  always @(posedge clock_i)
    rdata_o <= re_i ? {8'h3c, addr_i ^ 16'h5a5a} : ~rdata_o;
endmodule

//--- tb/prog_writer_monitor.sv
// ======
// checker on the top ports
module prog_writer_monitor (
  input wire logic clock_i, // clock
  input wire logic reset_n_i, // reset
  input wire logic [31:0] hwdata_i, // write data
  input wire logic hreadyout_o, // ready
  input wire logic hresp_o, // response
  input wire logic cpu_stall_o, // stall
  input wire logic slave_code_ram_we_o, // code write
  input wire logic [23:0] slave_code_ram_addr_o, // code addr
  input wire logic dram_re_o // data read
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  property p_resp; hreadyout_o && !hresp_o; endproperty
  a_resp: assert property (p_resp)
    else $error("bus answer not okay");
  property p_we_stall; slave_code_ram_we_o |-> cpu_stall_o; endproperty
  a_we_stall: assert property (p_we_stall)
    else $error("code write without stall");
  property p_re_stall; dram_re_o |-> cpu_stall_o; endproperty
  a_re_stall: assert property (p_re_stall)
    else $error("fetch without stall");
  property p_re_we; dram_re_o |-> ##2 slave_code_ram_we_o; endproperty
  a_re_we: assert property (p_re_we)
    else $error("fetched word not written");
  property p_launch; $rose(cpu_stall_o) |-> $past(hwdata_i[15]); endproperty
  a_launch: assert property (p_launch)
    else $error("stall without start write");
  property p_even;
    $rose(cpu_stall_o) |-> ##[1:8] (slave_code_ram_we_o && !slave_code_ram_addr_o[0]);
  endproperty
  a_even: assert property (p_even)
    else $error("first write not aligned");
  property p_done; $rose(cpu_stall_o) |-> ##[3:500] !cpu_stall_o; endproperty
  a_done: assert property (p_done)
    else $error("stall too long");
  property p_pulse; slave_code_ram_we_o |=> !slave_code_ram_we_o; endproperty
  a_pulse: assert property (p_pulse)
    else $error("code write too long");
endmodule
bind runtime_program_memory_writer prog_writer_monitor i_prog_writer_monitor (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .hwdata_i(hwdata_i),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .cpu_stall_o(cpu_stall_o),
  .slave_code_ram_we_o(slave_code_ram_we_o), .slave_code_ram_addr_o(slave_code_ram_addr_o), .dram_re_o(dram_re_o));

//--- tb/runtime_program_memory_writer_tb.sv
`include "prog_writer_map.vh"
// ======
// bench
module runtime_program_memory_writer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_n_i, hsel, hwrite, rdy, resp, stall, irq, we, re;
  logic [31:0] haddr, hwdata, hrdata, r, tgt, l0, l1;
  logic [1:0] htrans;
  logic [23:0] pa, pd, dd;
  logic [15:0] da;
  logic [23:0] qa[$], qd[$];
  int err_count, checked;
  runtime_program_memory_writer i_runtime_program_memory_writer (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp),
    .cpu_stall_o(stall), .irq_o(irq), .slave_code_ram_we_o(we), .slave_code_ram_addr_o(pa),
    .slave_code_ram_wdata_o(pd), .dram_re_o(re), .dram_addr_o(da), .dram_rdata_i(dd));
  data_ram_partner i_data_ram_partner (
    .clock_i(clock_i), .re_i(re), .addr_i(da), .rdata_o(dd));
  initial
  begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
    if (we)
    begin
      qa.push_back(pa);
      qd.push_back(pd);
    end
  function logic [23:0] ram_word(input logic [15:0] a);
    return {8'h3c, a ^ 16'h5a5a};
  endfunction
  task check(input string name, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wait_rdy;
    int n;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (rdy !== 1'b1 && n < 100);
    if (rdy !== 1'b1)
    begin
      err_count++;
      give_verdict;
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  task launch(input logic [3:0] op, input logic [23:0] t);
    xfer(1, `OFS_ADDR_LO, {16'h0, t[15:0]});
    xfer(1, `OFS_ADDR_HI, {24'h0, t[23:16]});
    xfer(1, `OFS_CONTROL, {28'h0000400, op});
    xfer(1, `OFS_KEY, {24'h0, `KEY_FIRST});
    xfer(1, `OFS_KEY, {24'h0, `KEY_SECOND});
    xfer(1, `OFS_CONTROL, {28'h0000c00, op});
    @(posedge clock_i);
  endtask
  task wait_idle;
    int n;
    n = 0;
    do
    begin
      xfer(0, `OFS_CONTROL, 0);
      n++;
    end
    while (r[15] !== 1'b0 && n < 300);
    if (r[15] !== 1'b0)
    begin
      err_count++;
      give_verdict;
    end
  endtask
  initial
  begin
    reset_n_i = 0;
    hsel = 1;
    hwrite = 0;
    htrans = 0;
    haddr = 0;
    hwdata = 0;
    r = $urandom(15);
    repeat (5) @(posedge clock_i);
    reset_n_i <= 1;
    xfer(0, `OFS_CONTROL, 0);
    check("control", r, 0);
    xfer(1, `OFS_KEY, 32'hffff);
    xfer(0, `OFS_KEY, 0);
    check("key", r, 0);
    xfer(0, 8'h40, 0);
    check("unmapped", r, 0);
    l0 = $urandom;
    xfer(1, `OFS_SRC, l0);
    xfer(0, `OFS_SRC, 0);
    check("source", r, l0 & 32'hffff);
    xfer(1, `OFS_MASK, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      tgt = i == 0 ? 0 : i == 1 ? 32'hfffffe : $urandom & 32'hfffffe;
      l0 = $urandom & 32'hffffff;
      l1 = $urandom & 32'hffffff;
      xfer(1, `OFS_LATCH0, l0);
      xfer(1, `OFS_LATCH1, l1);
      launch(`OP_DOUBLE, tgt[23:0]);
      check("stall", stall, 1);
      wait_idle;
      check("irq", irq, 1);
      check("count", qa.size(), 2);
      for (int k = 0; k < 2; k++)
      begin
        check("addr", qa[k], tgt + k);
        check("data", qd[k], k ? l1 : l0);
      end
      xfer(0, `OFS_STATUS, 0);
      check("status", r, 1);
      xfer(0, `OFS_STATUS, 0);
      check("irq", irq, 0);
      qa.delete();
      qd.delete();
    end
    launch(`OP_DOUBLE, 24'h000101);
    wait_idle;
    check("error", r[13], 1);
    xfer(0, `OFS_STATUS, 0);
    check("refused", r, 2);
    xfer(1, `OFS_CONTROL, 32'h4001);
    xfer(1, `OFS_CONTROL, 32'hc001);
    wait_idle;
    check("no key", qa.size(), 0);
    xfer(1, `OFS_MASK, 0);
    tgt = $urandom & 32'h7fff80;
    l0 = $urandom;
    xfer(1, `OFS_SRC, l0);
    launch(`OP_ROW, tgt[23:0]);
    wait_idle;
    check("irq masked", irq, 0);
    check("row", qa.size(), `ROW_WORDS);
    for (int k = 0; k < qa.size(); k++)
    begin
      check("row addr", qa[k], tgt + k);
      check("row data", qd[k], ram_word(l0[15:0] + k));
    end
    give_verdict;
  end
endmodule
